// ---- hw/dsf_pkg.sv ----
package dsf_pkg;
    // Frame validation counts
    localparam logic [5:0] EDGES_DUAL = 6'h20;
    localparam logic [5:0] EDGES_SINGLE = 6'h30;
    localparam logic [5:0] EDGES_READ = 6'h30;
    localparam logic [5:0] EDGE_CMD_LAST = 6'h0f;
    localparam logic [5:0] EDGE_MSB_PREV = 6'h0f;
    localparam logic [5:0] EDGE_MAX = 6'h3f;
    // Command codes in bits 15:12
    localparam logic [3:0] CMD_NOP = 4'h0;
    localparam logic [3:0] CMD_RD_REF_FIRST = 4'h1;
    localparam logic [3:0] CMD_RD_REF_SECOND = 4'h2;
    localparam logic [3:0] CMD_RD_CFG = 4'h3;
    localparam logic [3:0] CMD_WR_CFG = 4'h8;
    localparam logic [3:0] CMD_WR_REF_FIRST = 4'h9;
    localparam logic [3:0] CMD_WR_REF_SECOND = 4'ha;
    localparam int CMD_NOOP_BIT = 14;
    // Field layout
    localparam int CMD_W = 16;
    localparam int CFG_W = 12;
    localparam int REF_W = 9;
    localparam int REF_LSB = 3;
    localparam int IFACE_HI = 11;
    localparam int IFACE_LO = 10;
    localparam logic [1:0] IFACE_DUAL = 2'h0;
    localparam logic [1:0] IFACE_SINGLE = 2'h1;
    localparam logic [11:0] CFG_RESET = 12'h000;
    localparam logic [8:0] REF_RESET = 9'h000;
    // Conversion timing
    localparam int CLK_PERIOD_NS = 40;
    localparam int CONVERSION_INTERVAL_NS = 600;
    localparam int CONV_CYCLES_INT = (CONVERSION_INTERVAL_NS / CLK_PERIOD_NS < 1) ? 1 :
        CONVERSION_INTERVAL_NS / CLK_PERIOD_NS;
    localparam logic [5:0] CONV_CYCLES = 6'(CONV_CYCLES_INT);
endpackage

// ---- hw/dsf_frame_if.sv ----
// Function
// [R1] Frame spans chip select low period
// [R2] Need 32 or 48 falling edges
// [R3] Valid frame commits write at select rise
// [R4] Short frame leaves registers unchanged
// [R5] First 16 input bits form command
// [R6] Host holds input low without update
// [R7] Decode command bits 15:12 to operations
// [R8] Read command needs zero low bits, 48 edges; code checks edges only, ignores bits 11:0
// [R9] Next frame shifts register on first output
// [R10] Readback word: code, config or level
// [R11] Write during readback frame commits normally
// [R12] Conversion finishes within sixteen clock periods
// [R13] Config bits 11:10 select interface mode
// [R14] Dual mode: each output carries own channel
// [R15] Select fall drives outputs low
// [R16] After conversion return to sampling
// [R17] MSB at sixteenth edge, then lower bits
// [R18] Select rise tristates outputs
// [R19] Early select rise aborts, resumes sampling
// [R20] Command sent most significant bit first
// [R21] Host samples outputs on rising edge
`timescale 1ns/1ps
`default_nettype none
module dsf_frame_if (
    // System clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Serial link
    input wire logic sclk,
    input wire logic cs_b,
    input wire logic serial_in,
    output logic serial_out_first,
    output logic serial_out_first_oe,
    output logic serial_out_second,
    output logic serial_out_second_oe,
    // Converter core
    input wire logic [15:0] result_first,
    input wire logic [15:0] result_second,
    output logic conv_start,
    output logic sample_hold,
    // Programmed settings
    output logic [11:0] config_word,
    output logic [8:0] ref_level_first,
    output logic [8:0] ref_level_second
);
    logic cs_s1_reg, cs_s2_reg, cs_s3_reg, cs_low_reg;
    logic frame_start, frame_end;
    logic [5:0] conv_cnt_reg;
    logic hold_reg, start_reg;
    logic [15:0] res_first_reg, res_second_reg;
    logic [11:0] cfg_reg;
    logic [8:0] ref_first_reg, ref_second_reg;
    logic [15:0] rb_word_reg;
    logic rb_pend_reg;
    logic [5:0] need;
    logic valid, valid_read, single;
    logic [3:0] code;
    // Link domain
    logic armed_reg;
    logic [5:0] edge_cnt_reg;
    logic [15:0] cmd_reg;
    logic [31:0] sh_first_reg;
    logic [15:0] sh_second_reg;
    logic rb_frame_reg;

    assign single = cfg_reg[dsf_pkg::IFACE_HI:dsf_pkg::IFACE_LO] == dsf_pkg::IFACE_SINGLE;
    assign need = single ? dsf_pkg::EDGES_SINGLE : dsf_pkg::EDGES_DUAL; // [R2] [R13]
    assign code = cmd_reg[15:12];
    assign valid = edge_cnt_reg >= need;
    assign valid_read = edge_cnt_reg >= dsf_pkg::EDGES_READ; // [R8]

    // Chip select synchroniser into the system clock
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            cs_s1_reg <= 1'b1;
            cs_s2_reg <= 1'b1;
            cs_s3_reg <= 1'b1;
        end else begin
            cs_s1_reg <= cs_b;
            cs_s2_reg <= cs_s1_reg;
            cs_s3_reg <= cs_s2_reg;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            cs_low_reg <= 1'b0;
        end else if (cs_s2_reg == cs_s3_reg) begin
            cs_low_reg <= ~cs_s3_reg; // [R1]
        end
    end

    assign frame_start = !cs_low_reg && cs_s2_reg == cs_s3_reg && !cs_s3_reg;
    assign frame_end = cs_low_reg && cs_s2_reg == cs_s3_reg && cs_s3_reg;

    // Conversion timing and sample-and-hold control
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            conv_cnt_reg <= 6'h00;
            hold_reg <= 1'b0;
        end else if (frame_start) begin
            conv_cnt_reg <= dsf_pkg::CONV_CYCLES; // [R12]
            hold_reg <= 1'b1;
        end else if (frame_end) begin
            conv_cnt_reg <= 6'h00; // [R19]
            hold_reg <= 1'b0;
        end else if (conv_cnt_reg != 6'h00) begin
            conv_cnt_reg <= conv_cnt_reg - 6'h01;
            if (conv_cnt_reg == 6'h01) begin
                hold_reg <= 1'b0; // [R16]
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            start_reg <= 1'b0;
        end else begin
            start_reg <= frame_start;
        end
    end

    // Results held for the link until the next conversion ends
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            res_first_reg <= 16'h0000;
            res_second_reg <= 16'h0000;
        end else if (conv_cnt_reg == 6'h01 && !frame_end) begin
            res_first_reg <= result_first; // [R12] [R14]
            res_second_reg <= result_second;
        end
    end

    // Register commit at the frame end
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            cfg_reg <= dsf_pkg::CFG_RESET;
            ref_first_reg <= dsf_pkg::REF_RESET;
            ref_second_reg <= dsf_pkg::REF_RESET;
        end else if (frame_end && valid && !cmd_reg[dsf_pkg::CMD_NOOP_BIT]) begin // [R3] [R4]
            unique case (code) // [R11]
                dsf_pkg::CMD_WR_CFG: cfg_reg <= cmd_reg[11:0]; // [R7]
                dsf_pkg::CMD_WR_REF_FIRST: ref_first_reg <= cmd_reg[11:dsf_pkg::REF_LSB];
                dsf_pkg::CMD_WR_REF_SECOND: ref_second_reg <= cmd_reg[11:dsf_pkg::REF_LSB];
                default: cfg_reg <= cfg_reg;
            endcase
        end
    end

    // Readback word for the following frame
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            rb_pend_reg <= 1'b0;
            rb_word_reg <= 16'h0000;
        end else if (frame_end) begin
            rb_pend_reg <= 1'b0;
            if (valid_read && !cmd_reg[dsf_pkg::CMD_NOOP_BIT]) begin
                unique case (code)
                    dsf_pkg::CMD_RD_CFG: begin
                        rb_pend_reg <= 1'b1; // [R10]
                        rb_word_reg <= {dsf_pkg::CMD_RD_CFG, cfg_reg};
                    end
                    dsf_pkg::CMD_RD_REF_FIRST: begin
                        rb_pend_reg <= 1'b1;
                        rb_word_reg <= {dsf_pkg::CMD_RD_REF_FIRST, ref_first_reg, 3'h0};
                    end
                    dsf_pkg::CMD_RD_REF_SECOND: begin
                        rb_pend_reg <= 1'b1;
                        rb_word_reg <= {dsf_pkg::CMD_RD_REF_SECOND, ref_second_reg, 3'h0};
                    end
                    default: rb_pend_reg <= 1'b0;
                endcase
            end
        end
    end

    // Link side: first-edge marker, preset while select is high
    always_ff @(negedge sclk or posedge cs_b) begin
        if (cs_b) begin
            armed_reg <= 1'b1;
        end else begin
            armed_reg <= 1'b0;
        end
    end

    // Edge count and command word survive the select rise for the commit
    always_ff @(negedge sclk) begin
        if (armed_reg) begin
            edge_cnt_reg <= 6'h01;
        end else if (edge_cnt_reg != dsf_pkg::EDGE_MAX) begin
            edge_cnt_reg <= edge_cnt_reg + 6'h01; // [R2]
        end
    end

    always_ff @(negedge sclk) begin
        if (armed_reg) begin
            cmd_reg <= {15'h0000, serial_in}; // [R5] [R20]
        end else if (edge_cnt_reg <= dsf_pkg::EDGE_CMD_LAST) begin
            cmd_reg <= {cmd_reg[14:0], serial_in};
        end
    end

    // Output shifters, cleared while select is high
    always_ff @(negedge sclk or posedge cs_b) begin
        if (cs_b) begin
            rb_frame_reg <= 1'b0;
            sh_first_reg <= 32'h00000000; // [R15]
            sh_second_reg <= 16'h0000;
        end else if (armed_reg) begin
            rb_frame_reg <= rb_pend_reg;
            sh_first_reg <= rb_pend_reg ? {rb_word_reg, 16'h0000} : 32'h00000000; // [R9]
            sh_second_reg <= 16'h0000;
        end else if (edge_cnt_reg == dsf_pkg::EDGE_MSB_PREV && !rb_frame_reg) begin
            sh_first_reg <= {res_first_reg, single ? res_second_reg : 16'h0000}; // [R17]
            sh_second_reg <= single ? 16'h0000 : res_second_reg; // [R14]
        end else begin
            sh_first_reg <= {sh_first_reg[30:0], 1'b0};
            sh_second_reg <= {sh_second_reg[14:0], 1'b0};
        end
    end

    assign serial_out_first = sh_first_reg[31];
    assign serial_out_second = sh_second_reg[15];
    assign serial_out_first_oe = ~cs_b; // [R15] [R18]
    assign serial_out_second_oe = ~cs_b && !single; // [R13]
    assign conv_start = start_reg;
    assign sample_hold = hold_reg;
    assign config_word = cfg_reg;
    assign ref_level_first = ref_first_reg;
    assign ref_level_second = ref_second_reg;

    // Checks
    logic [5:0] hold_age_reg;
    always_ff @(posedge clk) begin
        if (!rst_b || !hold_reg) begin
            hold_age_reg <= 6'h00;
        end else if (hold_age_reg != dsf_pkg::EDGE_MAX) begin
            hold_age_reg <= hold_age_reg + 6'h01;
        end
    end

    AST_HOLD_BOUND: assert property (@(posedge clk) disable iff (!rst_b) // [R12]
        hold_age_reg <= dsf_pkg::CONV_CYCLES)
        else $error("conversion hold too long");
    AST_HOLD_ON_START: assert property (@(posedge clk) disable iff (!rst_b) // [R1]
        frame_start |=> sample_hold && conv_start ##1 !conv_start)
        else $error("frame start did not begin conversion");
    AST_ABORT_SAMPLE: assert property (@(posedge clk) disable iff (!rst_b) // [R19]
        frame_end |=> !sample_hold && conv_cnt_reg == 6'h00)
        else $error("frame end left hold active");
    AST_DONE_SAMPLE: assert property (@(posedge clk) disable iff (!rst_b) // [R16]
        (conv_cnt_reg == 6'h01 && !frame_start && !frame_end) |=> !sample_hold)
        else $error("hold not released after conversion");
    AST_NO_WRITE_MIDFRAME: assert property (@(posedge clk) disable iff (!rst_b) // [R3]
        !frame_end |=>
            $stable(config_word) && $stable(ref_level_first) && $stable(ref_level_second))
        else $error("register changed outside frame end");
    AST_SHORT_FRAME: assert property (@(posedge clk) disable iff (!rst_b) // [R4]
        (frame_end && edge_cnt_reg < need) |=>
            $stable(config_word) && $stable(ref_level_first) && $stable(ref_level_second))
        else $error("short frame changed a register");
    AST_CFG_WRITE: assert property (@(posedge clk) disable iff (!rst_b) // [R7]
        (frame_end && valid && code == dsf_pkg::CMD_WR_CFG) |=>
            config_word == $past(cmd_reg[11:0]))
        else $error("config write not committed");
    AST_REF_WRITE: assert property (@(posedge clk) disable iff (!rst_b) // [R7]
        (frame_end && valid && code == dsf_pkg::CMD_WR_REF_SECOND) |=>
            ref_level_second == $past(cmd_reg[11:3]) && $stable(config_word))
        else $error("second level write not committed");
    AST_RB_CFG: assert property (@(posedge clk) disable iff (!rst_b) // [R10]
        (frame_end && valid_read && code == dsf_pkg::CMD_RD_CFG) |=>
            rb_pend_reg && rb_word_reg == {4'h3, config_word})
        else $error("config readback word wrong");
    AST_MSB_LAUNCH: assert property (@(negedge sclk) disable iff (cs_b) // [R17]
        (!armed_reg && edge_cnt_reg == 6'h0f && !rb_frame_reg) |=>
            serial_out_first == res_first_reg[15])
        else $error("msb not launched at sixteenth edge");
    AST_REF_FIRST_WRITE: assert property (@(posedge clk) disable iff (!rst_b) // [R7]
        (frame_end && valid && code == dsf_pkg::CMD_WR_REF_FIRST) |=>
            ref_level_first == $past(cmd_reg[11:dsf_pkg::REF_LSB]) && $stable(ref_level_second))
        else $error("first level write not committed");
    AST_NOP_KEEPS: assert property (@(posedge clk) disable iff (!rst_b) // [R7]
        (frame_end && (code[2] || code == 4'hb || code == dsf_pkg::CMD_NOP)) |=>
            $stable(config_word) && $stable(ref_level_first) && $stable(ref_level_second))
        else $error("no-op code changed a register");
    AST_RB_REF_FIRST: assert property (@(posedge clk) disable iff (!rst_b) // [R10]
        (frame_end && valid_read && code == dsf_pkg::CMD_RD_REF_FIRST) |=>
            rb_pend_reg && rb_word_reg == {dsf_pkg::CMD_RD_REF_FIRST, ref_level_first, 3'h0})
        else $error("first level readback word wrong");
    AST_RB_REF_SECOND: assert property (@(posedge clk) disable iff (!rst_b) // [R10]
        (frame_end && valid_read && code == dsf_pkg::CMD_RD_REF_SECOND) |=>
            rb_pend_reg && rb_word_reg == {dsf_pkg::CMD_RD_REF_SECOND, ref_level_second, 3'h0})
        else $error("second level readback word wrong");
    AST_CONV_LOW: assert property (@(negedge sclk) disable iff (cs_b) // [R15]
        (!armed_reg && !rb_frame_reg && edge_cnt_reg < dsf_pkg::EDGE_MSB_PREV) |->
            !serial_out_first && !serial_out_second)
        else $error("output not low during conversion");
    AST_RB_TAIL: assert property (@(negedge sclk) disable iff (cs_b) // [R9]
        (!armed_reg && rb_frame_reg) |->
            !serial_out_second && (edge_cnt_reg <= 6'(dsf_pkg::CMD_W) || !serial_out_first))
        else $error("readback frame output not zero");
endmodule
`default_nettype wire

// ---- verif/dsf_host_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module dsf_host_model (
    // Serial link
    output logic sclk,
    output logic cs_b,
    output logic serial_in,
    input wire logic serial_out_first,
    input wire logic serial_out_second,
    // Captured output bits
    output logic [63:0] rx_first,
    output logic [63:0] rx_second
);
    initial begin
        sclk = 1'b1;
        cs_b = 1'b0;
        serial_in = 1'b0;
        rx_first = '0;
        rx_second = '0;
        // Select rise once at start so the link side begins preset
        #1;
        cs_b = 1'b1;
    end
    // One frame of n falling edges, serial clock idle high outside frames
    task automatic frame(input logic [15:0] cmd, input int n);
        // Odd lead-in keeps link edges off the system clock phase
        #13;
        cs_b = 1'b0;
        serial_in = cmd[15];
        #40;
        for (int i = 1; i <= n; i++) begin
            sclk = 1'b0;
            #40;
            sclk = 1'b1;
            rx_first = {rx_first[62:0], serial_out_first};
            rx_second = {rx_second[62:0], serial_out_second};
            serial_in = (i < 16) ? cmd[15-i] : 1'b0;
            #40;
        end
        cs_b = 1'b1;
        serial_in = ~serial_in;
        #400;
    endtask
endmodule
`default_nettype wire

// ---- verif/dsf_frame_if_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module dsf_frame_if_tb;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic sclk, cs_b, serial_in, conv_start, sample_hold;
    logic serial_out_first, serial_out_first_oe, serial_out_second, serial_out_second_oe;
    logic [15:0] result_first = 16'h0000;
    logic [15:0] result_second = 16'h0000;
    logic [11:0] config_word;
    logic [8:0] ref_level_first, ref_level_second;
    logic [63:0] rx_first, rx_second;
    logic line_first, line_second;
    // Undriven outputs reach the host inverted
    assign line_first = serial_out_first_oe ? serial_out_first : ~serial_out_first;
    assign line_second = serial_out_second_oe ? serial_out_second : ~serial_out_second;
    int num_errors = 0;
    int total_checks = 0;
    int starts = 0;
    always #20 clk = ~clk;
    always @(posedge clk) if (conv_start === 1'b1) starts <= starts + 1;
    dsf_frame_if uut (.clk(clk), .rst_b(rst_b), .sclk(sclk), .cs_b(cs_b),
        .serial_in(serial_in), .serial_out_first(serial_out_first),
        .serial_out_first_oe(serial_out_first_oe), .serial_out_second(serial_out_second),
        .serial_out_second_oe(serial_out_second_oe), .result_first(result_first),
        .result_second(result_second), .conv_start(conv_start), .sample_hold(sample_hold),
        .config_word(config_word), .ref_level_first(ref_level_first),
        .ref_level_second(ref_level_second));
    dsf_host_model host (.sclk(sclk), .cs_b(cs_b), .serial_in(serial_in),
        .serial_out_first(line_first), .serial_out_second(line_second),
        .rx_first(rx_first), .rx_second(rx_second));
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        total_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] %0t mismatch got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic results;
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    // Dual output conversion frame
    task automatic conversion_interval;
        int s;
        @(posedge clk) #1;
        result_first = 16'hc3a5;
        result_second = 16'h5a3c;
        s = starts;
        host.frame(16'h0000, 32);
        chk(rx_first[31:0], {15'h0000, 16'hc3a5, 1'b0});
        chk(rx_second[31:0], {15'h0000, 16'h5a3c, 1'b0});
        chk(starts - s, 1);
        chk({serial_out_first_oe, serial_out_second_oe}, 2'b00);
        chk(sample_hold, 1'b0);
    endtask
    // Writes, a short frame and no-op codes
    task automatic t_write;
        logic [3:0] nops[5] = '{4'h0, 4'hb, 4'h4, 4'hc, 4'he};
        host.frame({4'h9, 9'h1a5, 3'h0}, 32);
        chk(ref_level_first, 9'h1a5);
        host.frame({4'ha, 9'h0c3, 3'h0}, 32);
        chk(ref_level_second, 9'h0c3);
        host.frame({4'h8, 12'h0f1}, 32);
        chk(config_word, 12'h0f1);
        host.frame({4'ha, 9'h011, 3'h0}, 31);
        chk(ref_level_second, 9'h0c3);
        for (int i = 0; i < 5; i++) begin
            host.frame({nops[i], 12'h5a5}, 32);
            chk({config_word, ref_level_first, ref_level_second},
                {12'h0f1, 9'h1a5, 9'h0c3});
        end
    endtask
    // Readback of every register, then a write inside a readback frame
    task automatic t_read;
        logic [15:0] word[3] = '{{4'h1, 9'h1a5, 3'h0}, {4'h2, 9'h0c3, 3'h0}, {4'h3, 12'h0f1}};
        for (int i = 0; i < 3; i++) begin
            host.frame({word[i][15:12], 12'h000}, 48);
            host.frame(16'h0000, 48);
            chk(rx_first[47:0], {word[i], 32'h0});
            chk(rx_second[47:0], 48'h0);
        end
        host.frame({4'h2, 12'h000}, 48);
        host.frame({4'h8, 12'h0a2}, 48);
        chk(rx_first[47:32], {4'h2, 9'h0c3, 3'h0});
        chk(config_word, 12'h0a2);
    endtask
    // Single output mode and its edge count
    task automatic t_single;
        host.frame({4'h8, 12'h400}, 32);
        chk(config_word, 12'h400);
        host.frame({4'h8, 12'h000}, 32);
        chk(config_word, 12'h400);
        host.frame({4'h8, 12'h000}, 48);
        chk(rx_first[47:0], {15'h0000, 16'hc3a5, 16'h5a3c, 1'b0});
        chk(rx_second[47:0], 48'hffffffffffff);
        chk(config_word, 12'h000);
    endtask
    initial begin
        repeat (4) @(posedge clk);
        #1 rst_b = 1'b1;
        repeat (4) @(posedge clk);
        #1;
        chk({config_word, ref_level_first, ref_level_second}, 30'h0);
        conversion_interval;
        t_write;
        t_read;
        t_single;
        results;
    end
    initial begin
        #2000000;
        num_errors++;
        results;
    end
endmodule
`default_nettype wire
